/* core/ext_bus_pkg.sv */
// Function
// - Separate bus drives A0-A7 on pins
// - 8-bit mux shares A0-A7 with D0-D7
// - 16-bit mux shares A1-A7/D0-D6, A0 own
// - 16-bit mux shares A8/D7, A9-A15 plain
// - Separate bus drives A8-A15 on pins
// - A16-A19 driven on top pins
// - Four chip selects mark the accessed space
// - Clock pin gives main/8, main/32 or sub
// - Software picks byte strobes or strobe plus enable
// - Byte strobes: low lane even, high odd
// - Read happens only while read strobe low
// - Single strobe mode writes with strobe low
// - Upper lane enable low on odd addresses
// - Hold lasts while pause request stays low
// - Pause grant low while in hold
// - Address capture strobe latches the address
// - Ready input low stretches the bus cycle
// - Separate bus carries D0-D7 on own pins
package ext_bus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int TOP_W = 4;
    localparam int SPACE_N = 4;
    localparam int SPACE_W = 2;
    localparam int ODD_BIT = 0;
    localparam int MID_LSB = 8;
    localparam int TOP_LSB = 16;
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] DIV8_LAST = 5'h03;
    localparam logic [DIV_W-1:0] DIV32_LAST = 5'h0F;
    typedef enum logic [1:0] {
        CKO_DIV8 = 2'h0,
        CKO_DIV32 = 2'h1,
        CKO_SUB = 2'h2,
        CKO_OFF = 2'h3
    } cko_sel_t;
    // Gray order along idle, address, strobe, done
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_STRB = 3'h3,
        ST_DONE = 3'h2,
        ST_HOLD = 3'h6
    } bus_state_t;
endpackage : ext_bus_pkg

/* core/clk_out_gen.sv */
`timescale 1ns/1ps
module clk_out_gen (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [1:0] sel_i,
    input wire logic sub_osc_i,
    output logic clk_o
);
    logic [ext_bus_pkg::DIV_W-1:0] cnt_reg, cnt_next, last;
    logic out_next, sub_meta_reg, sub_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cnt_next = ext_bus_pkg::DIV_W'(cnt_reg + 1'h1);
        out_next = clk_o;
        last = (sel_i == ext_bus_pkg::CKO_DIV8) ? ext_bus_pkg::DIV8_LAST
                                                 : ext_bus_pkg::DIV32_LAST;
        if (!enable_i || sel_i == ext_bus_pkg::CKO_OFF)
        begin
            cnt_next = '0;
            out_next = 1'h0;
        end
        else if (sel_i == ext_bus_pkg::CKO_SUB)
        begin
            cnt_next = '0;
            out_next = sub_sync_reg;
        end
        else if (cnt_reg >= last)
        begin
            cnt_next = '0;
            out_next = ~clk_o;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            clk_o <= 1'h0;
            sub_meta_reg <= 1'h0;
            sub_sync_reg <= 1'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            clk_o <= out_next;
            sub_meta_reg <= sub_osc_i;
            sub_sync_reg <= sub_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    div8_rate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        enable_i && sel_i == ext_bus_pkg::CKO_DIV8 && $changed(clk_o) [*1] ##1
        (enable_i && sel_i == ext_bus_pkg::CKO_DIV8) [*4] |-> $changed(clk_o) && $past(clk_o) == $past(clk_o, 3))
        else $error("divide-by-8 half period not four clocks");
    div8_cover_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sel_i == ext_bus_pkg::CKO_DIV8 && enable_i && $rose(clk_o));
endmodule : clk_out_gen

/* core/ext_bus_master.sv */
`timescale 1ns/1ps
module ext_bus_master (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic wide_bus_n_i,
    input wire logic mux_bus_i,
    input wire logic single_strobe_i,
    input wire logic single_chip_i,
    input wire logic [1:0] clk_out_sel_i,
    input wire logic sub_oscillator_input_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_word_i,
    input wire logic [19:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic [1:0] req_space_i,
    output logic accept_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic [7:0] addr_lo_o,
    output logic [7:0] addr_lo_oe_n_o,
    input wire logic [7:0] addr_lo_i,
    output logic [7:0] addr_mid_o,
    output logic addr_a8_oe_n_o,
    input wire logic addr_a8_i,
    output logic [3:0] addr_top_o,
    output logic [7:0] data_lo_o,
    output logic data_lo_oe_n_o,
    input wire logic [7:0] data_lo_i,
    output logic [7:0] data_hi_o,
    output logic data_hi_oe_n_o,
    input wire logic [7:0] data_hi_i,
    output logic [3:0] space_select_lines_n_o,
    output logic store_strobe_low_lane_n_o,
    output logic store_strobe_high_lane_n_o,
    output logic read_strobe_n_o,
    output logic address_capture_strobe_o,
    output logic pause_grant_n_o,
    input wire logic bus_pause_request_n_i,
    input wire logic wait_ready_input_n_i,
    output logic external_bus_clock_o,
    output logic clock_output_pin_o
);
    localparam int BW = ext_bus_pkg::BYTE_W;
    localparam int DW = ext_bus_pkg::DATA_W;
    localparam int OB = ext_bus_pkg::ODD_BIT;

    logic rst_meta_reg, rst_n;
    ext_bus_pkg::bus_state_t state_reg, state_next;
    logic [ext_bus_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [DW-1:0] wdata_reg, wdata_next, rdata_next, rd_word;
    logic [ext_bus_pkg::SPACE_W-1:0] space_reg, space_next;
    logic we_reg, we_next, word_reg, word_next;
    logic accept_next, done_next, bclk_next;
    logic wide, mux16, lane_lo, lane_hi, upper_hit, in_cycle, data_ph, wr_ph, strb;
    logic hold, drive;
    logic [BW-1:0] byte_lo, byte_hi, rd_lo;
    logic [BW-1:0] addr_lo_next, addr_lo_oe_n_next, addr_mid_next;
    logic [BW-1:0] data_lo_next, data_hi_next;
    logic [ext_bus_pkg::TOP_W-1:0] addr_top_next;
    logic [ext_bus_pkg::SPACE_N-1:0] cs_n_next;
    logic a8_oe_n_next, data_lo_oe_n_next, data_hi_oe_n_next;
    logic stl_n_next, sth_n_next, rd_n_next, ale_next, grant_n_next;

    ////////////////////////////////////////////////////////////////////////////
    // Reset released through two stages
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_reg <= 1'h0;
            rst_n <= 1'h0;
        end
        else
        begin
            rst_meta_reg <= 1'h1;
            rst_n <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    clk_out_gen u_clk_out (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .enable_i(single_chip_i),
        .sel_i(clk_out_sel_i),
        .sub_osc_i(sub_oscillator_input_i),
        .clk_o(clock_output_pin_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        wide = ~wide_bus_n_i;
        mux16 = mux_bus_i & wide;
        // read byte gathered from data, shared or shifted pins
        rd_lo = ~mux_bus_i ? data_lo_i :
                mux16 ? {addr_a8_i, addr_lo_i[BW-1:1]} : addr_lo_i;
        if (word_reg && wide)
            rd_word = {data_hi_i, rd_lo};
        else if (wide && addr_reg[OB])
            rd_word = {{BW{1'h0}}, data_hi_i};
        else
            rd_word = {{BW{1'h0}}, rd_lo};
        state_next = state_reg;
        bclk_next = ~external_bus_clock_o;
        addr_next = addr_reg;
        we_next = we_reg;
        word_next = word_reg;
        wdata_next = wdata_reg;
        space_next = space_reg;
        rdata_next = rdata_o;
        accept_next = 1'h0;
        done_next = 1'h0;
        // phases advance on bus clock falling edge
        if (external_bus_clock_o)
        begin
            unique case (state_reg)
                ext_bus_pkg::ST_IDLE:
                begin
                    if (!bus_pause_request_n_i)
                        state_next = ext_bus_pkg::ST_HOLD;
                    else if (req_i)
                    begin
                        state_next = ext_bus_pkg::ST_ADDR;
                        addr_next = req_addr_i;
                        we_next = req_write_i;
                        word_next = req_word_i;
                        wdata_next = req_wdata_i;
                        space_next = req_space_i;
                        accept_next = 1'h1;
                    end
                end
                ext_bus_pkg::ST_ADDR:
                    state_next = ext_bus_pkg::ST_STRB;
                ext_bus_pkg::ST_STRB:
                begin
                    // cycle stretched while ready held low
                    if (wait_ready_input_n_i)
                    begin
                        state_next = ext_bus_pkg::ST_DONE;
                        if (!we_reg)
                            rdata_next = rd_word;
                    end
                end
                ext_bus_pkg::ST_DONE:
                begin
                    state_next = ext_bus_pkg::ST_IDLE;
                    done_next = 1'h1;
                end
                ext_bus_pkg::ST_HOLD:
                begin
                    if (bus_pause_request_n_i)
                        state_next = ext_bus_pkg::ST_IDLE;
                end
                default:
                    state_next = ext_bus_pkg::ST_IDLE;
            endcase
        end

        // Pins follow the next state so that every output is a flop
        lane_hi = wide & (word_next | addr_next[OB]);
        lane_lo = ~wide | word_next | ~addr_next[OB];
        upper_hit = addr_next[OB] | (word_next & wide);
        byte_lo = wdata_next[BW-1:0];
        byte_hi = word_next ? wdata_next[DW-1:BW] : byte_lo;
        strb = state_next == ext_bus_pkg::ST_STRB;
        hold = state_next == ext_bus_pkg::ST_HOLD;
        data_ph = strb || state_next == ext_bus_pkg::ST_DONE;
        in_cycle = data_ph || state_next == ext_bus_pkg::ST_ADDR;
        wr_ph = data_ph & we_next;
        drive = ~hold;

        // low address on its own pins
        addr_lo_next = addr_next[BW-1:0];
        addr_lo_oe_n_next = {BW{hold}};
        // middle address on its own pins
        addr_mid_next = addr_next[ext_bus_pkg::MID_LSB +: BW];
        a8_oe_n_next = hold;
        addr_top_next = addr_next[ext_bus_pkg::TOP_LSB +: ext_bus_pkg::TOP_W];
        // separate data pins driven only for writes
        data_lo_next = byte_lo;
        data_lo_oe_n_next = ~(wr_ph & ~mux_bus_i);
        data_hi_next = byte_hi;
        data_hi_oe_n_next = ~(wr_ph & wide & lane_hi);
        if (mux_bus_i)
        begin
            // shared pins carry address until data phase
            addr_lo_oe_n_next = {BW{~((state_next == ext_bus_pkg::ST_ADDR) | wr_ph)}};
            if (data_ph)
            begin
                if (mux16)
                begin
                    // A0 kept, A1-A7 give way to D0-D6
                    addr_lo_next = {byte_lo[BW-2:0], addr_next[OB]};
                    addr_lo_oe_n_next[OB] = ~drive;
                    addr_mid_next[0] = byte_lo[BW-1];
                    a8_oe_n_next = ~we_next;
                end
                else
                begin
                    addr_lo_next = byte_lo;
                end
            end
            else if (mux16)
                addr_lo_oe_n_next[OB] = ~drive;
        end

        // one select low for the active space
        cs_n_next = '1;
        if (in_cycle)
            cs_n_next[space_next] = 1'h0;
        // read strobe only in read data phase
        rd_n_next = ~(strb & ~we_next);
        // strobe scheme chosen at run time
        if (single_strobe_i)
        begin
            stl_n_next = ~(strb & we_next);
            // upper lane enable over whole cycle
            sth_n_next = ~(in_cycle & upper_hit);
        end
        else
        begin
            stl_n_next = ~(strb & we_next & lane_lo);
            sth_n_next = ~(strb & we_next & lane_hi);
        end
        ale_next = state_next == ext_bus_pkg::ST_ADDR;
        grant_n_next = ~hold;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ext_bus_pkg::ST_IDLE;
            addr_reg <= '0;
            we_reg <= 1'h0;
            word_reg <= 1'h0;
            wdata_reg <= '0;
            space_reg <= '0;
            rdata_o <= '0;
            accept_o <= 1'h0;
            done_o <= 1'h0;
            external_bus_clock_o <= 1'h0;
            addr_lo_o <= '0;
            addr_lo_oe_n_o <= '0;
            addr_mid_o <= '0;
            addr_a8_oe_n_o <= 1'h0;
            addr_top_o <= '0;
            data_lo_o <= '0;
            data_lo_oe_n_o <= 1'h1;
            data_hi_o <= '0;
            data_hi_oe_n_o <= 1'h1;
            space_select_lines_n_o <= '1;
            store_strobe_low_lane_n_o <= 1'h1;
            store_strobe_high_lane_n_o <= 1'h1;
            read_strobe_n_o <= 1'h1;
            address_capture_strobe_o <= 1'h0;
            pause_grant_n_o <= 1'h1;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            we_reg <= we_next;
            word_reg <= word_next;
            wdata_reg <= wdata_next;
            space_reg <= space_next;
            rdata_o <= rdata_next;
            accept_o <= accept_next;
            done_o <= done_next;
            external_bus_clock_o <= bclk_next;
            addr_lo_o <= addr_lo_next;
            addr_lo_oe_n_o <= addr_lo_oe_n_next;
            addr_mid_o <= addr_mid_next;
            addr_a8_oe_n_o <= a8_oe_n_next;
            addr_top_o <= addr_top_next;
            data_lo_o <= data_lo_next;
            data_lo_oe_n_o <= data_lo_oe_n_next;
            data_hi_o <= data_hi_next;
            data_hi_oe_n_o <= data_hi_oe_n_next;
            space_select_lines_n_o <= cs_n_next;
            store_strobe_low_lane_n_o <= stl_n_next;
            store_strobe_high_lane_n_o <= sth_n_next;
            read_strobe_n_o <= rd_n_next;
            address_capture_strobe_o <= ale_next;
            pause_grant_n_o <= grant_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode pins are straps; checks assume they stay put
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    ale_first_a: assert property ($fell(read_strobe_n_o) |->
        $past(address_capture_strobe_o) && $past(address_capture_strobe_o, 2))
        else $error("read strobe without preceding capture pulse");
    read_only_a: assert property (!read_strobe_n_o |-> !we_reg)
        else $error("read strobe low during a write");
    wait_stretch_a: assert property (state_reg == ext_bus_pkg::ST_STRB &&
        external_bus_clock_o && !wait_ready_input_n_i |=> state_reg == ext_bus_pkg::ST_STRB)
        else $error("cycle ended while ready held low");
    grant_enter_a: assert property (state_reg == ext_bus_pkg::ST_IDLE &&
        external_bus_clock_o && !bus_pause_request_n_i |=> !pause_grant_n_o)
        else $error("grant not given after pause request");
    hold_keep_a: assert property (!pause_grant_n_o && !bus_pause_request_n_i
        |=> !pause_grant_n_o && read_strobe_n_o && addr_lo_oe_n_o == '1)
        else $error("hold left or bus driven while request low");
    lane_low_a: assert property (!single_strobe_i && !wide_bus_n_i &&
        !store_strobe_low_lane_n_o |-> we_reg && (!addr_reg[OB] || word_reg))
        else $error("low lane strobe on odd byte");
    lane_high_a: assert property (!single_strobe_i && !wide_bus_n_i &&
        !store_strobe_high_lane_n_o |-> we_reg && (addr_reg[OB] || word_reg))
        else $error("high lane strobe on even byte");
    single_wr_a: assert property (single_strobe_i && we_reg &&
        state_reg == ext_bus_pkg::ST_STRB |-> !store_strobe_low_lane_n_o)
        else $error("write strobe missing in single strobe mode");
    upper_odd_a: assert property (single_strobe_i && addr_reg[OB] &&
        state_reg == ext_bus_pkg::ST_STRB |-> !store_strobe_high_lane_n_o)
        else $error("upper lane enable high on odd access");
    mux8_addr_a: assert property (mux_bus_i && wide_bus_n_i &&
        state_reg == ext_bus_pkg::ST_ADDR |-> addr_lo_o == addr_reg[BW-1:0] &&
        addr_lo_oe_n_o == '0)
        else $error("shared pins not carrying address");
    mux16_a0_a: assert property (mux_bus_i && !wide_bus_n_i &&
        state_reg == ext_bus_pkg::ST_STRB |-> addr_lo_o[OB] == addr_reg[OB] &&
        !addr_lo_oe_n_o[OB] && addr_mid_o[BW-1:1] == addr_reg[BW+BW-1:BW+1])
        else $error("A0 or A9-A15 lost during data phase");
    space_sel_a: assert property (state_reg == ext_bus_pkg::ST_STRB |->
        !space_select_lines_n_o[space_reg] && $countones(space_select_lines_n_o) == 3)
        else $error("chip select not one-hot for space");
    cycle_len_a: assert property (accept_o ##1 wait_ready_input_n_i [*4] |->
        ##2 done_o)
        else $error("ready cycle not finished in time");

    read_c: cover property ($rose(done_o) && !we_reg);
    write_c: cover property ($rose(done_o) && we_reg && mux_bus_i);
    hold_c: cover property ($fell(pause_grant_n_o));
    wait_c: cover property (!read_strobe_n_o && !wait_ready_input_n_i [*4]);
endmodule : ext_bus_master

/* tb/ext_mem_model.sv */
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic sys_clk_i,
    input wire logic mux_i,
    input wire logic wide_n_i,
    input wire logic single_i,
    input wire logic [2:0] waits_i,
    input wire logic bus_clk_i,
    input wire logic lo_n_i,
    input wire logic hi_n_i,
    input wire logic rd_n_i,
    input wire logic capture_i,
    input wire logic [7:0] lo_pin_i,
    input wire logic a8_pin_i,
    input wire logic [7:0] mid_i,
    input wire logic [3:0] top_i,
    input wire logic [7:0] dlo_pin_i,
    input wire logic [7:0] dhi_pin_i,
    output logic [19:0] addr_o,
    output logic ready_n_o,
    output logic [7:0] drv_lo_o,
    output logic drv_a8_o,
    output logic [7:0] drv_dlo_o,
    output logic [7:0] drv_dhi_o
);
    logic [7:0] mem [256];
    logic [2:0] wait_cnt = 3'h0;
    logic [7:0] last_lo = 8'h00;
    logic [7:0] last_hi = 8'h00;
    logic [7:0] lane_lo, out_lo, out_hi, a_even, a_odd;
    logic wr, we_lo, we_hi, active;
    initial addr_o = 20'h00000;
    assign lane_lo = !mux_i ? dlo_pin_i : (wide_n_i ? lo_pin_i : {a8_pin_i, lo_pin_i[7:1]});
    assign a_even = {addr_o[7:1], 1'b0};
    assign a_odd = {addr_o[7:1], 1'b1};
    // width fixed, single strobe on either bus width
    assign wr = single_i && !lo_n_i;
    assign we_lo = single_i ? (wr && (wide_n_i || !addr_o[0])) : !lo_n_i;
    assign we_hi = !wide_n_i && !hi_n_i && (!single_i || wr);
    assign active = !rd_n_i || we_lo || we_hi;
    assign ready_n_o = !(active && wait_cnt < waits_i);
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        if (!rd_n_i)
        begin
            out_lo = wide_n_i ? mem[addr_o[7:0]] : mem[a_even];
            out_hi = mem[a_odd];
        end
        else
        begin
            // Released lines: inverse of last value, never a stale match
            out_lo = ~last_lo;
            out_hi = ~last_hi;
        end
    end
    assign drv_lo_o = (mux_i && !wide_n_i) ? {out_lo[6:0], out_lo[7]} : out_lo;
    assign drv_a8_o = out_lo[7];
    assign drv_dlo_o = out_lo;
    assign drv_dhi_o = out_hi;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i)
    begin
        if (capture_i)
            addr_o <= {top_i, mid_i[7:1], a8_pin_i, lo_pin_i};
        if (!active)
            wait_cnt <= 3'h0;
        else if (bus_clk_i && wait_cnt < waits_i)
            wait_cnt <= wait_cnt + 3'h1;
        if (we_lo)
            mem[wide_n_i ? addr_o[7:0] : a_even] <= lane_lo;
        if (we_hi)
            mem[a_odd] <= dhi_pin_i;
        if (!rd_n_i)
        begin
            last_lo <= out_lo;
            last_hi <= out_hi;
        end
    end
endmodule : ext_mem_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic mux; logic wide_n; logic single; logic word;
        logic [19:0] addr; logic [15:0] wdata; logic [15:0] rdata; logic lo; logic hi;
    } row_t;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wide_n = 1'b0, mux = 1'b0, single = 1'b0, chip = 1'b0, sub_osc = 1'b0;
    logic [1:0] clk_sel = 2'h3, space = 2'h0;
    logic req = 1'b0, req_wr = 1'b0, req_word = 1'b0, pause_n = 1'b1;
    logic [19:0] addr = 20'h00000, pm_addr;
    logic [15:0] wdata = 16'h0000, rdata, cyc;
    logic [2:0] waits = 3'h0;
    logic accept, done, a8_oe_n, a8_pin, dlo_oe_n, dhi_oe_n, lo_n, hi_n, rd_n, cap, grant_n;
    logic bclk, cko, ready_n, drv_a8, seen_lo, seen_hi, seen_rd;
    logic [7:0] lo_o, lo_oe_n, lo_pin, mid, dlo_o, dhi_o, dlo_pin, dhi_pin, drv_lo, drv_dlo, drv_dhi;
    logic [3:0] top, sel_n, seen_sel;
    int err_total = 0;
    int n_tests = 0;
    int p;
    row_t rows [8] = '{
        '{1'b0, 1'b0, 1'b0, 1'b1, 20'h12344, 16'hBEEF, 16'hBEEF, 1'b1, 1'b1},
        '{1'b0, 1'b0, 1'b0, 1'b0, 20'h00105, 16'h005A, 16'h005A, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b0, 1'b0, 20'h00106, 16'h00C3, 16'h00C3, 1'b1, 1'b0},
        '{1'b1, 1'b1, 1'b1, 1'b0, 20'hABC37, 16'h0096, 16'h0096, 1'b1, 1'b1},
        '{1'b1, 1'b1, 1'b1, 1'b0, 20'h5A0C8, 16'h0071, 16'h0071, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b0, 1'b1, 20'hF0F12, 16'h1234, 16'h1234, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b1, 1'b0, 20'h3FE81, 16'h00A5, 16'h00A5, 1'b1, 1'b1},
        '{1'b0, 1'b1, 1'b1, 1'b0, 20'h00040, 16'hAA55, 16'h0055, 1'b1, 1'b0}
    };
    row_t r;
    always #12.5 sys_clk_i = ~sys_clk_i;
    always
    begin
        repeat (7) @(posedge sys_clk_i);
        sub_osc <= ~sub_osc;
    end
    // Wire level from every driver's enable
    assign lo_pin = (lo_oe_n & drv_lo) | (~lo_oe_n & lo_o);
    assign a8_pin = a8_oe_n ? drv_a8 : mid[0];
    assign dlo_pin = dlo_oe_n ? drv_dlo : dlo_o;
    assign dhi_pin = dhi_oe_n ? drv_dhi : dhi_o;
    ext_bus_master dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wide_bus_n_i(wide_n),
        .mux_bus_i(mux), .single_strobe_i(single), .single_chip_i(chip), .clk_out_sel_i(clk_sel),
        .sub_oscillator_input_i(sub_osc), .req_i(req), .req_write_i(req_wr), .req_word_i(req_word),
        .req_addr_i(addr), .req_wdata_i(wdata), .req_space_i(space), .accept_o(accept),
        .done_o(done), .rdata_o(rdata), .addr_lo_o(lo_o), .addr_lo_oe_n_o(lo_oe_n),
        .addr_lo_i(lo_pin), .addr_mid_o(mid), .addr_a8_oe_n_o(a8_oe_n), .addr_a8_i(a8_pin),
        .addr_top_o(top), .data_lo_o(dlo_o), .data_lo_oe_n_o(dlo_oe_n), .data_lo_i(dlo_pin),
        .data_hi_o(dhi_o), .data_hi_oe_n_o(dhi_oe_n), .data_hi_i(dhi_pin),
        .space_select_lines_n_o(sel_n), .store_strobe_low_lane_n_o(lo_n),
        .store_strobe_high_lane_n_o(hi_n), .read_strobe_n_o(rd_n),
        .address_capture_strobe_o(cap), .pause_grant_n_o(grant_n),
        .bus_pause_request_n_i(pause_n), .wait_ready_input_n_i(ready_n),
        .external_bus_clock_o(bclk), .clock_output_pin_o(cko));
    ext_mem_model pm (.sys_clk_i(sys_clk_i), .mux_i(mux), .wide_n_i(wide_n), .single_i(single),
        .waits_i(waits), .bus_clk_i(bclk), .lo_n_i(lo_n), .hi_n_i(hi_n), .rd_n_i(rd_n),
        .capture_i(cap), .lo_pin_i(lo_pin), .a8_pin_i(a8_pin), .mid_i(mid), .top_i(top),
        .dlo_pin_i(dlo_pin), .dhi_pin_i(dhi_pin), .addr_o(pm_addr), .ready_n_o(ready_n),
        .drv_lo_o(drv_lo), .drv_a8_o(drv_a8), .drv_dlo_o(drv_dlo), .drv_dhi_o(drv_dhi));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic do_reset(input logic m, input logic w, input logic s);
        reset_n_i <= 1'b0;
        mux <= m;
        wide_n <= w;
        single <= s;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
    endtask : do_reset
    task automatic do_cycle(input logic wr, input logic wd, input logic [19:0] a,
        input logic [15:0] d, input logic [1:0] sp);
        int n;
        n = 0;
        {seen_lo, seen_hi, seen_rd, seen_sel, cyc} = {3'h0, 4'hF, 16'h0000};
        req <= 1'b1;
        req_wr <= wr;
        req_word <= wd;
        addr <= a;
        wdata <= d;
        space <= sp;
        while (accept !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        req <= 1'b0;
        while (done !== 1'b1 && n < 80)
        begin
            @(posedge sys_clk_i);
            n++;
            cyc++;
            {seen_lo, seen_hi, seen_rd} |= {~lo_n, ~hi_n, ~rd_n};
            seen_sel &= sel_n;
        end
        if (n >= 80)
        begin
            chk("cycle_timeout", 20'h1, 20'h0);
            test_done();
        end
    endtask : do_cycle
    task automatic clk_period(output int per);
        int n;
        n = 0;
        per = 0;
        repeat (40) @(posedge sys_clk_i);
        while (!(cko === 1'b0) && n < 100)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (cko !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        do
        begin
            @(posedge sys_clk_i);
            per++;
        end while (!(cko === 1'b0) && per < 100);
        while (cko !== 1'b1 && per < 100)
        begin
            @(posedge sys_clk_i);
            per++;
        end
    endtask : clk_period
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(1'b0, 1'b0, 1'b0);
        chk("reset_idle", {rd_n, lo_n, grant_n, sel_n, cap}, {3'h7, 4'hF, 1'b0});
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            do_reset(r.mux, r.wide_n, r.single);
            do_cycle(1'b1, r.word, r.addr, r.wdata, i[1:0]);
            chk("wr_low_lane", seen_lo, r.lo);
            chk("wr_high_lane", seen_hi, r.hi);
            chk("select", seen_sel, 4'(~(4'h1 << i[1:0])));
            chk("latched_addr", pm_addr, r.addr);
            do_cycle(1'b0, r.word, r.addr, 16'h0000, i[1:0]);
            chk("read_strobe", seen_rd, 1'b1);
            chk("rd_no_store", seen_lo, 1'b0);
            chk("rd_upper", seen_hi, r.single & r.hi);
            chk("rdata", rdata, r.rdata);
            chk("cycle_len", cyc, 16'd6);
        end
        // Slow memory: two low ready samples add two bus clocks
        waits <= 3'h2;
        do_cycle(1'b0, 1'b0, 20'h00040, 16'h0000, 2'h1);
        chk("wait_len", cyc, 16'd10);
        waits <= 3'h0;
        pause_n <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk("grant_low", grant_n, 1'b0);
        chk("data_released", dlo_oe_n, 1'b1);
        req <= 1'b1;
        p = 0;
        repeat (12)
        begin
            @(posedge sys_clk_i);
            p += int'(accept === 1'b1);
        end
        chk("accept_in_hold", 20'(p), 20'h0);
        chk("grant_held", grant_n, 1'b0);
        req <= 1'b0;
        pause_n <= 1'b1;
        @(posedge sys_clk_i);
        do_cycle(1'b0, 1'b0, 20'h00040, 16'h0000, 2'h0);
        chk("after_hold", {grant_n, rdata}, {1'b1, 16'h0055});
        chip <= 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            clk_sel <= s[1:0];
            clk_period(p);
            chk("clk_out_period", 20'(p), 20'((s == 0) ? 8 : ((s == 1) ? 32 : 14)));
        end
        test_done();
    end
endmodule : tb_top
